/* File: alarm_qualifier.v */
// Consecutive-period counters for the six blockage detections.
// Assumes period_end_in pulses once per diagnostic period on mclk_in.
`timescale 1ns/10ps
module alarm_qualifier (
  input wire mclk_in,
  input wire rst_in,
  input wire ce_in,
  input wire run_in,
  input wire period_end_in,
  input wire [5:0] exceed_in,
  input wire [3:0] supp_count_in,
  output wire [5:0] alarm_out
);
  // A zero count would alarm with no evidence, so treat it as one
  wire [3:0] need = (supp_count_in == 4'h0) ? 4'h1 : supp_count_in;

  // ==========================================================================
  // One saturating counter per detection
  genvar i;
  generate
    for (i = 0; i < 6; i = i + 1) begin : det
      reg [3:0] cnt_q;
      always @(posedge mclk_in) begin
        if (rst_in) begin
          cnt_q <= 4'h0;
        end else if (ce_in) begin
          if (!run_in) begin
            cnt_q <= 4'h0;
          end else if (period_end_in) begin
            if (!exceed_in[i]) begin
              cnt_q <= 4'h0;
            end else if (cnt_q != 4'hF) begin
              cnt_q <= cnt_q + 4'h1;
            end
          end
        end
      end
      assign alarm_out[i] = run_in && (cnt_q >= need);
    end
  endgenerate
endmodule

/* File: alarm_route_chk_sva.sv */
// Checker for config refusal, mask handling and alarm routing.
// Sees top ports only; settings with no readback, except the suppression count, are shadowed from writes.
`timescale 1ns/10ps
`include "blockage_alarm_map.vh"
module alarm_route_chk (
  input wire mclk_in,
  input wire rst_in,
  input wire ce_in,
  input wire cfg_wr_in,
  input wire [2:0] cfg_sel_in,
  input wire [15:0] cfg_data_in,
  input wire [3:0] process_limit_in,
  input wire [15:0] pv_current_in,
  input wire [15:0] ao_upper_in,
  input wire [15:0] ao_lower_in,
  input wire burnout_high_in,
  input wire cfg_reject_out,
  input wire [1:0] run_mode_out,
  input wire [15:0] alarm_notify_mask_out,
  input wire [15:0] diag_error_out,
  input wire [15:0] mean_diff_press_ratio_out,
  input wire [15:0] loop_current_out,
  input wire status_do_out,
  input wire [6:0] display_code_out
);
  // ============
  // Shadows; mode readback lags a cycle, so the limit check trusts Stop only when settled
  reg [1:0] opt_q;
  reg [2:0] dos_q;
  reg [15:0] fix_q, up_q, lo_q;
  wire wr = cfg_wr_in && ce_in;
  wire [15:0] d = cfg_data_in;
  wire [15:0] msk = diag_error_out & alarm_notify_mask_out;
  wire alert = |(msk & `LINK_MASK);
  wire [6:0] disp = |msk[7:2] ? `ABNORMAL_FOUND_CODE : (|msk[12:8] ? `NOT_APPLICABLE_CODE : 7'h00);
  wire stop = run_mode_out == `MODE_STOP;
  wire fix_ok = d >= `FIXED_OUT_MIN_UA && d <= `FIXED_OUT_MAX_UA;
  wire [15:0] r = mean_diff_press_ratio_out;
  always @(posedge mclk_in) begin
    if (rst_in) begin
      opt_q <= `OUT_OFF;
      dos_q <= `DO_SELECT_RESET;
      fix_q <= `FIXED_OUT_RESET;
      up_q <= `UPPER_LIMIT_RESET;
      lo_q <= `LOWER_LIMIT_RESET;
    end else if (wr) begin
      if (cfg_sel_in == `SEL_OUT_OPTION && d < 16'h0003)
        opt_q <= d[1:0];
      if (cfg_sel_in == `SEL_DO_SELECT && d < 16'h0006)
        dos_q <= d[2:0];
      if (cfg_sel_in == `SEL_FIXED_OUT && fix_ok)
        fix_q <= d;
      if (cfg_sel_in == `SEL_UPPER_LIMIT && stop)
        up_q <= d;
      if (cfg_sel_in == `SEL_LOWER_LIMIT && stop)
        lo_q <= d;
    end
  end
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  // ============
  // Properties
  property p_mask;
    wr && cfg_sel_in == `SEL_NOTIFY_MASK |-> ##2 alarm_notify_mask_out == ($past(cfg_data_in, 2) & `MASK_WRITABLE);
  endproperty
  a_mask: assert property (p_mask) else $error("mask write");
  property p_lim;
    wr && (cfg_sel_in == `SEL_UPPER_LIMIT || cfg_sel_in == `SEL_LOWER_LIMIT)
      && !$past(wr && cfg_sel_in == `SEL_RUN_MODE) |=> cfg_reject_out == $past(!stop);
  endproperty
  a_lim: assert property (p_lim) else $error("limit gate");
  property p_fix;
    wr && cfg_sel_in == `SEL_FIXED_OUT |=> cfg_reject_out == $past(!fix_ok);
  endproperty
  a_fix: assert property (p_fix) else $error("fixed range");
  property p_off;
    opt_q == `OUT_OFF && $past(opt_q) == `OUT_OFF && !$past(rst_in) |-> loop_current_out == $past(pv_current_in);
  endproperty
  a_off: assert property (p_off) else $error("off loop");
  property p_quiet;
    !alert && !$past(alert) && !$past(rst_in) |-> loop_current_out == $past(pv_current_in);
  endproperty
  a_quiet: assert property (p_quiet) else $error("quiet loop");
  property p_burn;
    opt_q == `OUT_BURNOUT && $past(opt_q) == `OUT_BURNOUT && alert && $past(alert)
      && $past(burnout_high_in, 4) == burnout_high_in
      |-> loop_current_out == (burnout_high_in ? $past(ao_upper_in) : $past(ao_lower_in));
  endproperty
  a_burn: assert property (p_burn) else $error("burnout loop");
  property p_fall;
    opt_q == `OUT_FALLBACK && $past(opt_q) == `OUT_FALLBACK && $stable(fix_q) && alert && $past(alert)
      |-> loop_current_out == fix_q;
  endproperty
  a_fall: assert property (p_fall) else $error("fallback loop");
  property p_stat;
    dos_q >= `DO_DIAG && $stable(dos_q) && alert == $past(alert) && $stable(process_limit_in)
      |-> status_do_out == (alert || (dos_q == `DO_ALL && |process_limit_in));
  endproperty
  a_stat: assert property (p_stat) else $error("status out");
  property p_out;
    $past(r, 2) == r && $past(up_q, 2) == up_q && $past(lo_q, 2) == lo_q
      |-> diag_error_out[`ERR_OUTSIDE] == ($signed(r) > $signed(up_q) || $signed(r) < $signed(lo_q));
  endproperty
  a_out: assert property (p_out) else $error("outside flag");
  property p_disp;
    msk == $past(msk) && !$past(rst_in) |-> display_code_out == disp;
  endproperty
  a_disp: assert property (p_disp) else $error("display code");
  c_burn: cover property (opt_q == `OUT_BURNOUT && alert);
  c_ref: cover property (run_mode_out == `MODE_REF ##1 run_mode_out == `MODE_CALC);
  c_rej: cover property (cfg_reject_out);
endmodule
bind blockage_diag_alarm_logic alarm_route_chk chk (.mclk_in, .rst_in, .ce_in, .cfg_wr_in, .cfg_sel_in,
  .cfg_data_in, .process_limit_in, .pv_current_in, .ao_upper_in, .ao_lower_in, .burnout_high_in,
  .cfg_reject_out, .run_mode_out, .alarm_notify_mask_out, .diag_error_out, .mean_diff_press_ratio_out,
  .loop_current_out, .status_do_out, .display_code_out);

/* File: blockage_alarm_map.vh */
// Constants for the impulse-line blockage alarm logic: selectors, reset values,
// field positions and timing counts. Assumes a 250 MHz mclk_in.
`ifndef BLOCKAGE_ALARM_MAP_VH
`define BLOCKAGE_ALARM_MAP_VH

// ==========================================================================
// Configuration write selectors
`define SEL_NOTIFY_MASK 3'h0
`define SEL_RUN_MODE 3'h1
`define SEL_UPPER_LIMIT 3'h2
`define SEL_LOWER_LIMIT 3'h3
`define SEL_OUT_OPTION 3'h4
`define SEL_FIXED_OUT 3'h5
`define SEL_DO_SELECT 3'h6
`define SEL_SUPP_COUNT 3'h7

// ==========================================================================
// Run modes, output options, status selector codes
`define MODE_STOP 2'h0
`define MODE_CALC 2'h1
`define MODE_REF 2'h2
`define OUT_OFF 2'h0
`define OUT_BURNOUT 2'h1
`define OUT_FALLBACK 2'h2
`define DO_DIAG 3'h4
`define DO_ALL 3'h5

// ==========================================================================
// Reset values and masks (ratios are signed Q2.14, currents in uA)
`define NOTIFY_MASK_RESET 16'h08FC
`define MASK_WRITABLE 16'h7FFC
`define LINK_MASK 16'h60FC
`define PREVENT_MASK 16'h1F00
`define UPPER_LIMIT_RESET 16'h3333
`define LOWER_LIMIT_RESET 16'hCCCD
`define FIXED_OUT_RESET 16'h0ED8
`define SUPP_COUNT_RESET 4'h3
`define DO_SELECT_RESET 3'h0

// ==========================================================================
// Limits and scales
`define RATIO_FRAC_BITS 14
`define FIXED_OUT_MIN_UA 16'h0ED8
`define FIXED_OUT_MAX_UA 16'h5460
`define FLUCT_DP_MIN 32'h0000_0046
`define FLUCT_SP_MIN 32'h0000_000A
`define BLOCKAGE_FACTOR_POS_LIMIT 16'h2000
`define BLOCKAGE_FACTOR_NEG_LIMIT 16'hE000
`define NOT_APPLICABLE_CODE 7'h58
`define ABNORMAL_FOUND_CODE 7'h59

// ==========================================================================
// Error word bit positions
`define ERR_BAD_F 8
`define ERR_BAD_SPH 9
`define ERR_BAD_SPL 10
`define ERR_BAD_DP 11
`define ERR_OUTSIDE 12
`define ERR_FT_LOW 13
`define ERR_FT_HIGH 14

// ==========================================================================
// Timing
`define SECOND_NS 1000000000
`define CLK_PERIOD_NS 4
`define SECOND_CYCLES (`SECOND_NS / `CLK_PERIOD_NS)
`define DIAG_PERIOD_SEC 180

`endif

/* File: blockage_diag_alarm_logic.v */
// Alarm qualification, masking and loop/status/display routing for the
// impulse-line blockage diagnostic. Configuration arrives from the HART
// command layer as a select/data write on mclk_in; the fluctuation values,
// raw threshold results and loop values are produced by logic on mclk_in.
// Only the burnout switch is a pin and is synchronised here.
`timescale 1ns/10ps
`include "blockage_alarm_map.vh"
module blockage_diag_alarm_logic #(
  parameter SECOND_CYCLES = `SECOND_CYCLES
) (
  input wire mclk_in,
  input wire rst_in,
  input wire ce_in,
  input wire cfg_wr_in,
  input wire [2:0] cfg_sel_in,
  input wire [15:0] cfg_data_in,
  input wire avg_dp_valid_in,
  input wire [15:0] avg_diff_press_in,
  input wire [15:0] max_span_in,
  input wire [31:0] diff_fluctuation_in,
  input wire [31:0] low_static_fluctuation_in,
  input wire [31:0] high_static_fluctuation_in,
  input wire [15:0] blockage_factor_in,
  input wire [5:0] raw_exceed_in,
  input wire blockage_factor_exceed_high_in,
  input wire blockage_factor_exceed_low_in,
  input wire flange_temp_low_in,
  input wire flange_temp_high_in,
  input wire [3:0] process_limit_in,
  input wire [15:0] pv_current_in,
  input wire [15:0] ao_upper_in,
  input wire [15:0] ao_lower_in,
  input wire burnout_high_in,
  output reg cfg_reject_out,
  output reg [1:0] run_mode_out,
  output reg [15:0] alarm_notify_mask_out,
  output reg [15:0] diag_error_out,
  output reg [15:0] mean_diff_press_ratio_out,
  output reg [15:0] reference_mean_dp_ratio_out,
  output reg [15:0] loop_current_out,
  output reg status_do_out,
  output reg [6:0] display_code_out
);
  localparam [31:0] SEC_FULL = SECOND_CYCLES - 1;
  localparam [27:0] SEC_LAST = SEC_FULL[27:0];
  localparam [31:0] PERIOD_FULL = `DIAG_PERIOD_SEC - 1;
  localparam [8:0] PERIOD_LAST = PERIOD_FULL[8:0];

  reg [1:0] mode_q;
  reg [15:0] mask_q;
  reg [15:0] upper_q;
  reg [15:0] lower_q;
  reg [1:0] out_opt_q;
  reg [15:0] fixed_q;
  reg [2:0] do_sel_q;
  reg [3:0] supp_q;
  reg [27:0] sec_cnt_q;
  reg [8:0] per_cnt_q;
  reg outside_q;
  reg bad_dp_q;
  reg bad_spl_q;
  reg bad_sph_q;
  reg bad_f_q;
  reg burn_meta_q;
  reg burn_sync_q;
  wire [15:0] ratio;
  wire ratio_done;
  wire [5:0] alarm;

  // ==========================================================================
  // Burnout switch is a pin, so two flops before use
  always @(posedge mclk_in) begin
    if (rst_in) begin
      burn_meta_q <= 1'b0;
      burn_sync_q <= 1'b0;
    end else if (ce_in) begin
      burn_meta_q <= burnout_high_in;
      burn_sync_q <= burn_meta_q;
    end
  end

  // ==========================================================================
  // Mean ratio of averaged DP to maximum span
  ratio_divider u_div (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .start_in(avg_dp_valid_in),
    .avg_dp_in(avg_diff_press_in),
    .span_in(max_span_in),
    .ratio_out(ratio),
    .done_out(ratio_done)
  );

  // ==========================================================================
  // Fluctuation adequacy and range checks
  wire fdp_ok = diff_fluctuation_in >= `FLUCT_DP_MIN;
  wire spl_ok = low_static_fluctuation_in >= `FLUCT_SP_MIN;
  wire sph_ok = high_static_fluctuation_in >= `FLUCT_SP_MIN;
  wire blockage_factor_ok = ($signed(blockage_factor_in) >= $signed(`BLOCKAGE_FACTOR_NEG_LIMIT)) &&
    ($signed(blockage_factor_in) <= $signed(`BLOCKAGE_FACTOR_POS_LIMIT));
  wire above = $signed(mean_diff_press_ratio_out) > $signed(upper_q);
  wire below = $signed(mean_diff_press_ratio_out) < $signed(lower_q);
  wire ref_out_of_range = above || below;
  wire limit_write = cfg_wr_in && (cfg_sel_in == `SEL_UPPER_LIMIT || cfg_sel_in == `SEL_LOWER_LIMIT);
  wire fixed_ok = (cfg_data_in >= `FIXED_OUT_MIN_UA) && (cfg_data_in <= `FIXED_OUT_MAX_UA);
  wire mode_ok = (cfg_data_in[15:2] == 14'h0000) && (cfg_data_in[1:0] != 2'h3);

  // ==========================================================================
  // Period timing: one-second prescaler then period counter
  wire sec_tick = (sec_cnt_q == SEC_LAST);
  wire period_end = sec_tick && (per_cnt_q == PERIOD_LAST);
  wire restart = cfg_wr_in && (cfg_sel_in == `SEL_RUN_MODE) && mode_ok;
  always @(posedge mclk_in) begin
    if (rst_in) begin
      sec_cnt_q <= 28'h000_0000;
      per_cnt_q <= 9'h000;
    end else if (ce_in) begin
      if (restart || mode_q == `MODE_STOP) begin
        sec_cnt_q <= 28'h000_0000;
        per_cnt_q <= 9'h000;
      end else if (sec_tick) begin
        sec_cnt_q <= 28'h000_0000;
        per_cnt_q <= period_end ? 9'h000 : (per_cnt_q + 9'h001);
      end else begin
        sec_cnt_q <= sec_cnt_q + 28'h000_0001;
      end
    end
  end

  // ==========================================================================
  // Configuration writes; limits only in Stop, fixed value only in range
  always @(posedge mclk_in) begin
    if (rst_in) begin
      mask_q <= `NOTIFY_MASK_RESET;
      upper_q <= `UPPER_LIMIT_RESET;
      lower_q <= `LOWER_LIMIT_RESET;
      out_opt_q <= `OUT_OFF;
      fixed_q <= `FIXED_OUT_RESET;
      do_sel_q <= `DO_SELECT_RESET;
      supp_q <= `SUPP_COUNT_RESET;
      cfg_reject_out <= 1'b0;
    end else if (ce_in) begin
      cfg_reject_out <= 1'b0;
      if (cfg_wr_in) begin
        if (cfg_sel_in == `SEL_NOTIFY_MASK) begin
          mask_q <= cfg_data_in & `MASK_WRITABLE;
        end else if (limit_write && mode_q != `MODE_STOP) begin
          cfg_reject_out <= 1'b1;
        end else if (cfg_sel_in == `SEL_UPPER_LIMIT) begin
          upper_q <= cfg_data_in;
        end else if (cfg_sel_in == `SEL_LOWER_LIMIT) begin
          lower_q <= cfg_data_in;
        end else if (cfg_sel_in == `SEL_RUN_MODE) begin
          cfg_reject_out <= !mode_ok;
        end else if (cfg_sel_in == `SEL_OUT_OPTION) begin
          if (cfg_data_in[15:2] == 14'h0000 && cfg_data_in[1:0] != 2'h3) begin
            out_opt_q <= cfg_data_in[1:0];
          end else begin
            cfg_reject_out <= 1'b1;
          end
        end else if (cfg_sel_in == `SEL_FIXED_OUT) begin
          if (fixed_ok) begin
            fixed_q <= cfg_data_in;
          end else begin
            cfg_reject_out <= 1'b1;
          end
        end else if (cfg_sel_in == `SEL_DO_SELECT) begin
          do_sel_q <= cfg_data_in[2:0];
        end else begin
          supp_q <= cfg_data_in[3:0];
        end
      end
    end
  end

  // ==========================================================================
  // Run mode, reference capture and validity flags
  always @(posedge mclk_in) begin
    if (rst_in) begin
      mode_q <= `MODE_STOP;
      bad_dp_q <= 1'b0;
      bad_spl_q <= 1'b0;
      bad_sph_q <= 1'b0;
      bad_f_q <= 1'b0;
      reference_mean_dp_ratio_out <= 16'h0000;
    end else if (ce_in) begin
      if (restart) begin
        mode_q <= cfg_data_in[1:0];
      end else if (mode_q == `MODE_REF && period_end) begin
        mode_q <= `MODE_CALC;
        reference_mean_dp_ratio_out <= mean_diff_press_ratio_out;
        if (ref_out_of_range) begin
          bad_dp_q <= 1'b1;
          bad_spl_q <= 1'b1;
          bad_sph_q <= 1'b1;
          bad_f_q <= 1'b1;
        end else begin
          bad_dp_q <= !fdp_ok;
          bad_spl_q <= !spl_ok;
          bad_sph_q <= !sph_ok;
          bad_f_q <= !blockage_factor_ok;
        end
      end
    end
  end

  // ==========================================================================
  // Ratio capture and outside-range flag
  always @(posedge mclk_in) begin
    if (rst_in) begin
      mean_diff_press_ratio_out <= 16'h0000;
      outside_q <= 1'b0;
    end else if (ce_in) begin
      if (ratio_done) begin
        mean_diff_press_ratio_out <= ratio;
      end
      outside_q <= above || below;
    end
  end

  // ==========================================================================
  // Detection gating; the outside-range flag suspends everything
  wire run = (mode_q == `MODE_CALC) && !outside_q && fdp_ok && !bad_dp_q;
  wire use_blockage_factor = !bad_f_q && blockage_factor_ok;
  wire low_ok = spl_ok && !bad_spl_q;
  wire high_ok = sph_ok && !bad_sph_q;
  wire [5:0] exceed;
  assign exceed[0] = raw_exceed_in[0];
  assign exceed[1] = raw_exceed_in[1] && low_ok;
  assign exceed[2] = raw_exceed_in[2] && high_ok;
  assign exceed[3] = (raw_exceed_in[3] || (blockage_factor_exceed_low_in && use_blockage_factor)) && low_ok;
  assign exceed[4] = (raw_exceed_in[4] || (blockage_factor_exceed_high_in && use_blockage_factor)) && high_ok;
  assign exceed[5] = raw_exceed_in[5];

  alarm_qualifier u_qual (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .run_in(run),
    .period_end_in(period_end),
    .exceed_in(exceed),
    .supp_count_in(supp_q),
    .alarm_out(alarm)
  );

  // ==========================================================================
  // Error word assembly and masking
  wire [15:0] err_word = {1'b0, flange_temp_high_in, flange_temp_low_in, outside_q, bad_dp_q,
    bad_spl_q, bad_sph_q, bad_f_q, alarm, 2'b00};
  wire [15:0] masked = diag_error_out & mask_q;
  wire alert = |(masked & `LINK_MASK);
  wire prevent = |(masked & `PREVENT_MASK);
  wire found = |masked[7:2];

  // ==========================================================================
  // Registered outputs: error word, loop current, status, display
  always @(posedge mclk_in) begin
    if (rst_in) begin
      diag_error_out <= 16'h0000;
      alarm_notify_mask_out <= `NOTIFY_MASK_RESET;
      run_mode_out <= `MODE_STOP;
      loop_current_out <= 16'h0000;
      status_do_out <= 1'b0;
      display_code_out <= 7'h00;
    end else if (ce_in) begin
      diag_error_out <= err_word;
      alarm_notify_mask_out <= mask_q;
      run_mode_out <= mode_q;
      if (!alert || out_opt_q == `OUT_OFF) begin
        loop_current_out <= pv_current_in;
      end else if (out_opt_q == `OUT_BURNOUT) begin
        loop_current_out <= burn_sync_q ? ao_upper_in : ao_lower_in;
      end else begin
        loop_current_out <= fixed_q;
      end
      case (do_sel_q)
        `DO_DIAG: status_do_out <= alert;
        `DO_ALL: status_do_out <= (|process_limit_in) || alert;
        3'h0: status_do_out <= process_limit_in[0];
        3'h1: status_do_out <= process_limit_in[1];
        3'h2: status_do_out <= process_limit_in[2];
        3'h3: status_do_out <= process_limit_in[3];
        default: status_do_out <= 1'b0;
      endcase
      if (found) begin
        display_code_out <= `ABNORMAL_FOUND_CODE;
      end else if (prevent) begin
        display_code_out <= `NOT_APPLICABLE_CODE;
      end else begin
        display_code_out <= 7'h00;
      end
    end
  end
endmodule

/* File: blockage_diag_alarm_logic_tb.sv */
// Bench for the blockage alarm block: config through the tool model.
// Assumes a second shortened to 10 cycles.
`timescale 1ns/10ps
`include "blockage_alarm_map.vh"
module blockage_diag_alarm_logic_tb;
  localparam PER = 10 * `DIAG_PERIOD_SEC;
  reg mclk_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1, avg_dp_valid_in = 1'b0;
  reg [15:0] avg_diff_press_in = 16'h0000, max_span_in = 16'h4000, blockage_factor_in = 16'h0000;
  reg [31:0] diff_fluctuation_in = `FLUCT_DP_MIN;
  reg [31:0] low_static_fluctuation_in = `FLUCT_SP_MIN, high_static_fluctuation_in = `FLUCT_SP_MIN;
  reg [5:0] raw_exceed_in = 6'h00;
  reg blockage_factor_exceed_high_in = 1'b0, blockage_factor_exceed_low_in = 1'b0, burnout_high_in = 1'b0;
  reg flange_temp_low_in = 1'b0, flange_temp_high_in = 1'b0;
  reg [3:0] process_limit_in = 4'h0;
  reg [15:0] pv_current_in = 16'h3A98, ao_upper_in = 16'h55F0, ao_lower_in = 16'h0E10;
  wire cfg_wr_in, cfg_reject_out, status_do_out;
  wire [2:0] cfg_sel_in;
  wire [1:0] run_mode_out;
  wire [15:0] cfg_data_in, alarm_notify_mask_out, diag_error_out, mean_diff_press_ratio_out;
  wire [15:0] reference_mean_dp_ratio_out, loop_current_out;
  wire [6:0] display_code_out;
  integer bad_count = 0, check_count = 0, rej_n = 0, n, k;
  always #2 mclk_in = ~mclk_in;
  hart_cfg_tool tool (.mclk_in, .cfg_wr_out(cfg_wr_in), .cfg_sel_out(cfg_sel_in), .cfg_data_out(cfg_data_in));
  blockage_diag_alarm_logic #(.SECOND_CYCLES(10)) uut (.mclk_in, .rst_in, .ce_in, .cfg_wr_in, .cfg_sel_in,
    .cfg_data_in, .avg_dp_valid_in, .avg_diff_press_in, .max_span_in, .diff_fluctuation_in,
    .low_static_fluctuation_in, .high_static_fluctuation_in, .blockage_factor_in, .raw_exceed_in,
    .blockage_factor_exceed_high_in, .blockage_factor_exceed_low_in, .flange_temp_low_in, .flange_temp_high_in, .process_limit_in,
    .pv_current_in, .ao_upper_in, .ao_lower_in, .burnout_high_in, .cfg_reject_out, .run_mode_out,
    .alarm_notify_mask_out, .diag_error_out, .mean_diff_press_ratio_out, .reference_mean_dp_ratio_out,
    .loop_current_out, .status_do_out, .display_code_out);
  // ============
  // Reject pulses are counted, so a check never races the one-cycle pulse
  always @(posedge mclk_in) if (cfg_reject_out === 1'b1) rej_n <= rej_n + 1;
  task chk(input [15:0] seen, input [15:0] exp, input [8*8:1] what);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("ERROR %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task tick(input integer c);
    begin
      repeat (c) @(posedge mclk_in);
      #1;
    end
  endtask
  task wr(input [2:0] sel, input [15:0] data, input rej);
    begin
      n = rej_n;
      tool.send(sel, data);
      tick(2);
      chk(rej_n - n, {15'h0, rej}, "reject");
    end
  endtask
  task set_ratio(input [15:0] v);
    begin
      avg_diff_press_in = v;
      avg_dp_valid_in = 1'b1;
      tick(1);
      avg_dp_valid_in = 1'b0;
      tick(40);
    end
  endtask
  // Bounded wait: sel below 16 waits for that error bit, else for Calculation
  task wait_for(input integer sel, input integer lim);
    begin
      n = 0;
      while (n < lim && (sel < 16 ? diag_error_out[sel] : run_mode_out == `MODE_CALC) !== 1'b1) begin
        tick(1);
        n = n + 1;
      end
      if (n == lim) begin
        bad_count = bad_count + 1;
        $display("ERROR wait %0d expired", sel);
        final_report;
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  // ============
  // Main sequence
  initial begin
    tick(12);
    rst_in = 1'b0;
    tick(2);
    ce_in = 1'b0;
    wr(`SEL_NOTIFY_MASK, 16'h0000, 1'b0);
    ce_in = 1'b1;
    chk(alarm_notify_mask_out, `NOTIFY_MASK_RESET, "mask");
    chk(run_mode_out, `MODE_STOP, "mode");
    wr(`SEL_NOTIFY_MASK, 16'hFFFF, 1'b0);
    chk(alarm_notify_mask_out, `MASK_WRITABLE, "mask");
    wr(`SEL_NOTIFY_MASK, `NOTIFY_MASK_RESET, 1'b0);
    wr(`SEL_OUT_OPTION, 16'h0001, 1'b0);
    wr(`SEL_DO_SELECT, 16'h0004, 1'b0);
    flange_temp_low_in = 1'b1;
    tick(4);
    chk(loop_current_out, pv_current_in, "loop");
    chk(status_do_out, 0, "status");
    wr(`SEL_NOTIFY_MASK, 16'h28FC, 1'b0);
    chk(status_do_out, 1, "status");
    wr(`SEL_FIXED_OUT, 16'h0ED7, 1'b1);
    wr(`SEL_FIXED_OUT, 16'h5461, 1'b1);
    wr(`SEL_FIXED_OUT, 16'h5460, 1'b0);
    wr(`SEL_OUT_OPTION, 16'h0003, 1'b1);
    for (k = 0; k < 3; k = k + 1) begin
      wr(`SEL_OUT_OPTION, k[15:0], 1'b0);
      tick(2);
      chk(loop_current_out, k == 0 ? pv_current_in : (k == 1 ? ao_lower_in : 16'h5460), "loop");
    end
    burnout_high_in = 1'b1;
    wr(`SEL_OUT_OPTION, 16'h0001, 1'b0);
    tick(4);
    chk(loop_current_out, ao_upper_in, "loop");
    flange_temp_low_in = 1'b0;
    process_limit_in = 4'h4;
    tick(3);
    chk(status_do_out, 0, "status");
    wr(`SEL_DO_SELECT, 16'h0005, 1'b0);
    chk(status_do_out, 1, "status");
    process_limit_in = 4'h0;
    $display("test routing done");
    wr(`SEL_NOTIFY_MASK, 16'h18FC, 1'b0);
    set_ratio(16'h2000);
    chk(mean_diff_press_ratio_out, 16'h2000, "ratio");
    chk(diag_error_out[12], 0, "outside");
    set_ratio(16'h3800);
    chk(diag_error_out[12], 1, "outside");
    chk(display_code_out, `NOT_APPLICABLE_CODE, "display");
    chk(loop_current_out, pv_current_in, "loop");
    set_ratio(16'hC800);
    chk(diag_error_out[12], 1, "outside");
    wr(`SEL_LOWER_LIMIT, 16'hC000, 1'b0);
    tick(3);
    chk(diag_error_out[12], 0, "outside");
    $display("test range done");
    set_ratio(16'h3800);
    wr(`SEL_RUN_MODE, 16'h0002, 1'b0);
    chk(run_mode_out, `MODE_REF, "mode");
    tick(PER - 20);
    chk(run_mode_out, `MODE_REF, "mode");
    wait_for(16, 60);
    tick(3);
    chk(diag_error_out[11:8], 4'hF, "bad ref");
    wr(`SEL_UPPER_LIMIT, 16'h3800, 1'b1);
    set_ratio(16'h2000);
    wr(`SEL_RUN_MODE, 16'h0002, 1'b0);
    wait_for(16, PER + 60);
    tick(3);
    chk(diag_error_out[11:8], 4'h0, "bad ref");
    $display("test reference done");
    low_static_fluctuation_in = `FLUCT_SP_MIN - 1;
    high_static_fluctuation_in = `FLUCT_SP_MIN - 1;
    raw_exceed_in = 6'h1F;
    tick(2 * PER + PER / 2);
    chk(diag_error_out[2], 0, "blocking");
    wait_for(2, PER);
    tick(2);
    chk(diag_error_out[6:3], 4'h0, "sides");
    chk(display_code_out, `ABNORMAL_FOUND_CODE, "display");
    chk(loop_current_out, ao_upper_in, "loop");
    $display("test blockage done");
    final_report;
  end
endmodule

/* File: hart_cfg_tool.sv */
// Configuration tool model on the HART side: single-word config writes.
// Assumes the device takes a write on the rising edge of mclk_in.
`timescale 1ns/10ps
module hart_cfg_tool (
  input wire mclk_in,
  output reg cfg_wr_out,
  output reg [2:0] cfg_sel_out,
  output reg [15:0] cfg_data_out
);
  // ============
  // Data is inverted between writes so a stale word never looks valid
  initial begin
    cfg_wr_out = 1'b0;
    cfg_sel_out = 3'h7;
    cfg_data_out = 16'hA5A5;
  end
  // One-cycle strobe launched just after an edge
  task send(input [2:0] sel, input [15:0] data);
    begin
      @(posedge mclk_in);
      #1;
      cfg_wr_out = 1'b1;
      cfg_sel_out = sel;
      cfg_data_out = data;
      @(posedge mclk_in);
      #1;
      cfg_wr_out = 1'b0;
      cfg_data_out = ~data;
    end
  endtask
endmodule

/* File: ratio_divider.v */
// Sequential signed divider producing the mean DP ratio in Q2.14.
// Assumes start is a single-cycle pulse from logic on mclk_in.
`timescale 1ns/10ps
`include "blockage_alarm_map.vh"
module ratio_divider (
  input wire mclk_in,
  input wire rst_in,
  input wire ce_in,
  input wire start_in,
  input wire [15:0] avg_dp_in,
  input wire [15:0] span_in,
  output reg [15:0] ratio_out,
  output reg done_out
);
  reg [29:0] dvd_q;
  reg [29:0] quo_q;
  reg [16:0] rem_q;
  reg [15:0] div_q;
  reg neg_q;
  reg [4:0] step_q;
  reg busy_q;
  reg fin_q;
  wire [16:0] rem_shift = {rem_q[15:0], dvd_q[29]};
  wire fits = rem_shift >= {1'b0, div_q};
  wire [15:0] mag = avg_dp_in[15] ? (~avg_dp_in + 16'h0001) : avg_dp_in;
  // Saturate so a zero or tiny span cannot wrap the sign
  wire [14:0] q_sat = (quo_q[29:15] != 15'h0000) ? 15'h7FFF : quo_q[14:0];

  // ==========================================================================
  // Restoring division, one quotient bit per clock
  always @(posedge mclk_in) begin
    if (rst_in) begin
      dvd_q <= 30'h0000_0000;
      quo_q <= 30'h0000_0000;
      rem_q <= 17'h0_0000;
      div_q <= 16'h0000;
      neg_q <= 1'b0;
      step_q <= 5'h00;
      busy_q <= 1'b0;
      fin_q <= 1'b0;
      ratio_out <= 16'h0000;
      done_out <= 1'b0;
    end else if (ce_in) begin
      fin_q <= 1'b0;
      done_out <= fin_q;
      if (start_in && !busy_q) begin
        dvd_q <= {mag, 14'h0000};
        quo_q <= 30'h0000_0000;
        rem_q <= 17'h0_0000;
        div_q <= span_in;
        neg_q <= avg_dp_in[15];
        step_q <= 5'h00;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        rem_q <= fits ? (rem_shift - {1'b0, div_q}) : rem_shift;
        quo_q <= {quo_q[28:0], fits};
        dvd_q <= {dvd_q[28:0], 1'b0};
        step_q <= step_q + 5'h01;
        if (step_q == 5'h1D) begin
          busy_q <= 1'b0;
          fin_q <= 1'b1;
        end
      end
      if (fin_q) begin // Ratio and done leave together, so no stale capture
        ratio_out <= neg_q ? (~{1'b0, q_sat} + 16'h0001) : {1'b0, q_sat};
      end
    end
  end
endmodule
